// File: rtl/touch_key_defines.svh
// register offsets, field positions, reset values and counter limits of
// the touch key scan block; included by the design
`ifndef TOUCH_KEY_DEFINES_SVH
`define TOUCH_KEY_DEFINES_SVH

// byte address layout: global group, module groups, threshold memory
`define ADDR_MOD_GROUP_BIT  7
`define ADDR_MEM_PAGE       6'h04
`define ADDR_UPPER_ZERO     4'h0

// word index inside the global group
`define IDX_SCAN_CTRL       3'd0
`define IDX_SCAN_STATUS     3'd1
`define IDX_FUNC_COUNT      3'd2

// word index inside a module group (module base 0x80 + n*0x20)
`define IDX_MOD_CFG         3'd0
`define IDX_SLOT_KEY_MAP    3'd1
`define IDX_THRESHOLD_HIGH  3'd2
`define IDX_THRESHOLD_LOW   3'd3
`define IDX_THRESHOLD_FLAGS 3'd4
`define IDX_CYCLE_COUNT     3'd5
`define IDX_SLOT_PERIOD     3'd6

// scan control fields
`define CTRL_MODE_LSB       0
`define CTRL_START_BIT      2
`define CTRL_SINGLE_BIT     3
`define CTRL_SHARED_BIT     4

// scan status fields
`define STAT_OVF_BIT        0
`define STAT_BUSY_BIT       1
`define STAT_SLOT_LSB       2

// module configuration fields
`define CFG_TSS_BIT         7
`define CFG_ROEN_BIT        5
`define CFG_KOEN_BIT        4

// threshold flags register: hit flags sit above the direction bits
`define THS_FLAG_LSB        4

// reset values
`define CTRL_RESET          8'h00
`define MAP_RESET           8'he4
`define THRESHOLD_RESET     8'h00
`define THS_RESET           8'h00
`define PERIOD_RESET        8'h00

// counter limits
`define UNIT_LAST           5'h1f
`define SLOT_LAST           8'hff

`endif

// File: rtl/touch_key_pkg.sv
// types shared by the touch key scan design
// assumes touch_key_defines.svh is on the include path
package touch_key_pkg;

	typedef enum logic [1:0] {
		MODE_AUTO       = 2'b00,
		MODE_MANUAL     = 2'b01,
		MODE_PERIODIC   = 2'b10,
		MODE_PERIODIC_B = 2'b11
	} scan_mode_e;

	// gray along idle -> scan -> slot end -> done -> idle
	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_SCAN     = 2'b01,
		ST_SLOT_END = 2'b11,
		ST_DONE     = 2'b10
	} scan_state_e;

	typedef struct packed {
		logic       tss;
		logic       roen;
		logic       koen;
		logic [3:0] key_en;
	} mod_cfg_s;

	typedef struct packed {
		logic [3:0]  ref_run;
		logic [15:0] key_run;
	} osc_run_s;

endpackage : touch_key_pkg

// File: rtl/touch_key_scan_threshold.sv
// touch key scan and threshold block: four modules of four keys each,
// apb register slave, slot sequencing, counters and threshold compare.
// assumes oscillator ticks and the rc clock level are synchronous to pclk.
//
// Overview of operation
// - each key has an enable bit; 1 makes its pin a touch input
// - disabled slot key: module oscillators stay off during that slot
// - slot key map holds 2-bit key codes for slots 0 to 3
// - slot 1..3 selections ignored in manual mode or single slot
// - slot 0 field picks the measured key in manual mode
// - periodic mode loads next slot threshold at each slot end
// - finished slot in periodic mode compares count with threshold; sets hit, signals event
// - flags register: hit flags bits 7..4, directions bits 3..0
// - manual mode raises overflow event when reference interval ends
// - shared select makes module 0 slot counter govern all modules
// - one scan start bit starts all modules
// - clearing start clears cycle, function, unit counters; slot counter kept
// - start rising edge switches on all four counters
// - slot counter overflow ending the last slot stops oscillators and all counters
// - slot counter clocked by reference osc or low-speed rc
// - oscillators run per reference and key oscillator enable bits
// - overflow event when all enabled modules or module 0 overflow
// - module n holds keys 4n+1 to 4n+4; module 0 differs: it always gets roen on an auto start, clocks the function counter and times shared slots
// - touch measured by counting key cycles in a fixed period
// - every key has its own sensing oscillator
// - mode 00 auto, 01 manual, 10 or 11 periodic auto
// - single slot: only slot 0 scans, slots 1..3 skipped
//
// Added by the designer: register access over APB and the address map.
`include "touch_key_defines.svh"

module touch_key_scan_threshold (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [15:0]            key_osc_tick,
	input  wire logic [3:0]             ref_osc_tick,
	input  wire logic                   low_speed_rc_clock,
	input  wire logic                   periodic_trigger,
	output logic      [15:0]            key_input_enable,
	output touch_key_pkg::osc_run_s     osc_run,
	output logic                        slot_overflow_pulse,
	output logic                        threshold_hit_pulse
);
	import touch_key_pkg::*;

	localparam int MODS = 4;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [1:0] slot_key(input logic [7:0] map,
	                                         input logic [1:0] slot);
		logic [1:0] k;
		k = map[1:0];
		unique case (slot)
			2'd0: k = map[1:0];
			2'd1: k = map[3:2];
			2'd2: k = map[5:4];
			2'd3: k = map[7:6];
		endcase
		return k;
	endfunction : slot_key

	function automatic logic past_threshold(input logic [15:0] cnt,
	                                        input logic [15:0] th,
	                                        input logic        upper);
		return upper ? (cnt > th) : (cnt < th);
	endfunction : past_threshold

	////////////////////////////////////////////////////////////////////////
	// state

	scan_state_e  state_reg;
	scan_state_e  state_next;
	logic [1:0]   slot_reg;
	logic [1:0]   mode_reg;
	logic         start_reg;
	logic         start_d_reg;
	logic         single_reg;
	logic         shared_reg;
	logic         lirc_d_reg;
	logic         ovf_evt_reg;
	logic [15:0]  func_reg;
	mod_cfg_s     cfg_reg      [MODS];
	logic [7:0]   map_reg      [MODS];
	logic [7:0]   thh_reg      [MODS];
	logic [7:0]   thl_reg      [MODS];
	logic [7:0]   ths_reg      [MODS];
	logic [7:0]   period_reg   [MODS];
	logic [7:0]   slot_cnt_reg [MODS];
	logic [15:0]  cyc_reg      [MODS];
	logic [4:0]   unit_reg     [MODS];
	logic [MODS-1:0] ovf_seen_reg;
	logic [15:0]  thr_mem      [16];
	logic [31:0]  rdata_reg;
	logic         err_reg;
	logic         ovf_pulse_reg;
	logic         hit_pulse_reg;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire        wr       = psel & penable & pwrite;
	wire        setup    = psel & ~penable;
	wire [2:0]  idx      = paddr[4:2];
	wire [1:0]  amod     = paddr[6:5];
	wire        in_low   = paddr[11:8] == `ADDR_UPPER_ZERO;
	wire        is_mod   = in_low & paddr[`ADDR_MOD_GROUP_BIT];
	wire        is_glob  = in_low & ~paddr[`ADDR_MOD_GROUP_BIT] &
	                       (paddr[6:5] == 2'd0);
	wire        is_mem   = paddr[11:6] == `ADDR_MEM_PAGE;
	wire        glob_ok  = is_glob & (idx <= `IDX_FUNC_COUNT);
	wire        mod_ok   = is_mod & (idx <= `IDX_SLOT_PERIOD);
	wire        addr_ok  = glob_ok | mod_ok | is_mem;
	wire        wr_glob  = wr & glob_ok;
	wire        wr_mod   = wr & mod_ok;
	wire        wr_mem   = wr & is_mem;

	////////////////////////////////////////////////////////////////////////
	// scan control

	wire manual     = mode_reg == MODE_MANUAL;
	wire periodic   = mode_reg[1];
	wire scanning   = state_reg == ST_SCAN;
	wire slot_end   = state_reg == ST_SLOT_END;
	wire busy       = state_reg != ST_IDLE;
	wire start_rise = start_reg & ~start_d_reg;
	wire restart    = periodic & start_reg & periodic_trigger;
	wire go         = (start_rise | restart) & ~busy;
	wire lirc_tick  = low_speed_rc_clock & ~lirc_d_reg;
	// manual and single slot runs end after slot 0
	wire last_slot  = manual | single_reg | (slot_reg == 2'd3);
	wire [1:0] eff_slot  = (manual | single_reg) ? 2'd0 : slot_reg;
	wire [1:0] next_slot = last_slot ? 2'd0 : slot_reg + 2'd1;

	logic [1:0]      sel_key [MODS];
	logic [MODS-1:0] mod_active;
	logic [MODS-1:0] ref_run;
	logic [MODS-1:0] ref_tick_g;
	logic [MODS-1:0] slot_tick;
	logic [MODS-1:0] ovf_now;
	logic [MODS-1:0] hit_any;
	logic [15:0]     key_run;

	for (genvar m = 0; m < MODS; m++) begin : g_mod
		assign sel_key[m]    = slot_key(map_reg[m], eff_slot);
		assign mod_active[m] = cfg_reg[m].key_en[sel_key[m]];
		assign ref_run[m]    = scanning & cfg_reg[m].roen &
		                       mod_active[m];
		for (genvar k = 0; k < 4; k++) begin : g_key
			assign key_run[m*4+k] = scanning & cfg_reg[m].koen &
			                        mod_active[m] &
			                        (sel_key[m] == 2'(k));
			assign key_input_enable[m*4+k] = cfg_reg[m].key_en[k];
		end
		assign ref_tick_g[m] = ref_osc_tick[m] & ref_run[m];
		// rc clock bypasses the 5-bit unit counter for a shorter slot
		assign slot_tick[m]  = scanning & mod_active[m] &
		                       (cfg_reg[m].tss ? lirc_tick :
		                        (ref_tick_g[m] &
		                         (unit_reg[m] == `UNIT_LAST)));
		assign ovf_now[m]    = slot_tick[m] &
		                       (slot_cnt_reg[m] == `SLOT_LAST);
		assign hit_any[m]    = slot_end & periodic & mod_active[m] &
		                       past_threshold(cyc_reg[m],
		                                      {thh_reg[m], thl_reg[m]},
		                                      ths_reg[m][sel_key[m]]);
	end

	wire [MODS-1:0] ovf_all = ovf_seen_reg | ovf_now;
	// modules whose slot key is disabled do not hold the slot open
	// a disabled module 0 slot key must not hang a shared-counter slot
	wire slot_done = scanning &
	                 (shared_reg ? (ovf_all[0] | ~mod_active[0]) :
	                  (&(ovf_all | ~mod_active)));

	assign osc_run = '{ref_run: ref_run, key_run: key_run};

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:     if (go) state_next = ST_SCAN;
			ST_SCAN:     if (slot_done) state_next = ST_SLOT_END;
			ST_SLOT_END: state_next = last_slot ? ST_DONE : ST_SCAN;
			ST_DONE:     state_next = ST_IDLE;
		endcase
		// dropping start aborts a run in progress
		if (!start_reg) begin
			state_next = ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// global registers

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= ST_IDLE;
			slot_reg    <= 2'd0;
			mode_reg    <= MODE_AUTO;
			start_reg   <= 1'b0;
			start_d_reg <= 1'b0;
			single_reg  <= 1'b0;
			shared_reg  <= 1'b0;
			lirc_d_reg  <= 1'b0;
			ovf_evt_reg <= 1'b0;
		end else begin
			state_reg   <= state_next;
			start_d_reg <= start_reg;
			lirc_d_reg  <= low_speed_rc_clock;
			if (go) begin
				slot_reg <= 2'd0;
			end else if (slot_end) begin
				slot_reg <= next_slot;
			end
			if (wr_glob && idx == `IDX_SCAN_CTRL) begin
				mode_reg   <= pwdata[`CTRL_MODE_LSB +: 2];
				start_reg  <= pwdata[`CTRL_START_BIT];
				single_reg <= pwdata[`CTRL_SINGLE_BIT];
				shared_reg <= pwdata[`CTRL_SHARED_BIT];
			end
			// set wins over a software clear in the same cycle
			if (state_reg == ST_DONE) begin
				ovf_evt_reg <= 1'b1;
			end else if (wr_glob && idx == `IDX_SCAN_STATUS &&
			             !pwdata[`STAT_OVF_BIT]) begin
				ovf_evt_reg <= 1'b0;
			end
		end
	end

	// function counter follows module 0 reference cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_reg <= 16'h0000;
		end else if (!start_reg || go || (slot_end && !last_slot)) begin
			func_reg <= 16'h0000;
		end else if (ref_tick_g[0]) begin
			func_reg <= func_reg + 16'h0001;
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_mem) begin
			thr_mem[paddr[5:2]] <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-module registers and counters

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int m = 0; m < MODS; m++) begin
				cfg_reg[m]      <= '0;
				map_reg[m]      <= `MAP_RESET;
				thh_reg[m]      <= `THRESHOLD_RESET;
				thl_reg[m]      <= `THRESHOLD_RESET;
				ths_reg[m]      <= `THS_RESET;
				period_reg[m]   <= `PERIOD_RESET;
				slot_cnt_reg[m] <= `PERIOD_RESET;
				cyc_reg[m]      <= 16'h0000;
				unit_reg[m]     <= 5'h00;
			end
			ovf_seen_reg <= '0;
		end else begin
			for (int m = 0; m < MODS; m++) begin
				if (wr_mod && amod == 2'(m)) begin
					unique case (idx)
						`IDX_MOD_CFG: cfg_reg[m] <= '{
							tss:    pwdata[`CFG_TSS_BIT],
							roen:   pwdata[`CFG_ROEN_BIT],
							koen:   pwdata[`CFG_KOEN_BIT],
							key_en: pwdata[3:0]};
						`IDX_SLOT_KEY_MAP:   map_reg[m] <= pwdata[7:0];
						`IDX_THRESHOLD_HIGH: thh_reg[m] <= pwdata[7:0];
						`IDX_THRESHOLD_LOW:  thl_reg[m] <= pwdata[7:0];
						`IDX_SLOT_PERIOD:    period_reg[m] <= pwdata[7:0];
						default: ;
					endcase
				end
				// hardware sets koen, and roen for module 0 or keyed modules without tss or shared select, on an auto start and clears both at done in every mode
				if (go && !manual) begin
					cfg_reg[m].koen <= 1'b1;
					cfg_reg[m].roen <= (m == 0) ||
					                   ((|cfg_reg[m].key_en) &&
					                    !cfg_reg[m].tss && !shared_reg);
				end else if (state_reg == ST_DONE) begin
					cfg_reg[m].koen <= 1'b0;
					cfg_reg[m].roen <= 1'b0;
				end
				if ((go || slot_end) && periodic) begin
					{thh_reg[m], thl_reg[m]} <=
						thr_mem[{2'(m), go ? 2'd0 : next_slot}];
				end
				// flags: write 0 clears, 1 keeps; a new hit always wins
				if (wr_mod && amod == 2'(m) &&
				    idx == `IDX_THRESHOLD_FLAGS) begin
					ths_reg[m][3:0] <= pwdata[3:0];
					ths_reg[m][7:4] <= (ths_reg[m][7:4] & pwdata[7:4]) |
						({3'b000, hit_any[m]} << sel_key[m]);
				end else if (hit_any[m]) begin
					ths_reg[m][`THS_FLAG_LSB + sel_key[m]] <= 1'b1;
				end
				if (!start_reg || go || (slot_end && !last_slot)) begin
					cyc_reg[m] <= 16'h0000;
				end else if (|(key_osc_tick[m*4 +: 4] & key_run[m*4 +: 4]))
				begin
					cyc_reg[m] <= cyc_reg[m] + 16'h0001;
				end
				if (!start_reg || go || slot_end) begin
					unit_reg[m] <= 5'h00;
				end else if (ref_tick_g[m]) begin
					unit_reg[m] <= unit_reg[m] + 5'h01;
				end
				// slot counter keeps its value when start drops
				if (go || slot_end || ovf_now[m]) begin
					slot_cnt_reg[m] <= period_reg[m];
				end else if (slot_tick[m]) begin
					slot_cnt_reg[m] <= slot_cnt_reg[m] + 8'h01;
				end
			end
			if (go || slot_end) begin
				ovf_seen_reg <= '0;
			end else begin
				ovf_seen_reg <= ovf_seen_reg | ovf_now;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb read path, captured in the setup phase

	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0000_0000;
		if (is_mem) begin
			rmux = {16'h0000, thr_mem[paddr[5:2]]};
		end else if (glob_ok) begin
			unique case (idx)
				`IDX_SCAN_CTRL: rmux = {27'h0, shared_reg, single_reg,
				                        start_reg, mode_reg};
				`IDX_SCAN_STATUS: rmux = {28'h0, slot_reg, busy,
				                          ovf_evt_reg};
				`IDX_FUNC_COUNT: rmux = {16'h0000, func_reg};
				default: ;
			endcase
		end else if (mod_ok) begin
			unique case (idx)
				`IDX_MOD_CFG: rmux = {24'h0, cfg_reg[amod].tss, 1'b0,
				                      cfg_reg[amod].roen,
				                      cfg_reg[amod].koen,
				                      cfg_reg[amod].key_en};
				`IDX_SLOT_KEY_MAP:    rmux = {24'h0, map_reg[amod]};
				`IDX_THRESHOLD_HIGH:  rmux = {24'h0, thh_reg[amod]};
				`IDX_THRESHOLD_LOW:   rmux = {24'h0, thl_reg[amod]};
				`IDX_THRESHOLD_FLAGS: rmux = {24'h0, ths_reg[amod]};
				`IDX_CYCLE_COUNT:     rmux = {16'h0000, cyc_reg[amod]};
				`IDX_SLOT_PERIOD:     rmux = {24'h0, period_reg[amod]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_reg     <= 32'h0000_0000;
			err_reg       <= 1'b0;
			ovf_pulse_reg <= 1'b0;
			hit_pulse_reg <= 1'b0;
		end else begin
			if (setup) begin
				rdata_reg <= pwrite ? 32'h0000_0000 : rmux;
				err_reg   <= ~addr_ok;
			end
			ovf_pulse_reg <= state_reg == ST_DONE;
			hit_pulse_reg <= |hit_any;
		end
	end

	assign prdata              = rdata_reg;
	assign pready              = 1'b1;
	assign pslverr             = err_reg & psel & penable;
	assign slot_overflow_pulse = ovf_pulse_reg;
	assign threshold_hit_pulse = hit_pulse_reg;

endmodule : touch_key_scan_threshold

// File: sim/touch_key_checker.sv
// assertions on the touch key scan block's ports
// assumes touch_key_pkg is compiled first; bound to the top module
module touch_key_checker (
	input wire logic                    pclk,
	input wire logic                    presetn,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [11:0]             paddr,
	input wire logic [31:0]             pwdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic [15:0]             key_input_enable,
	input wire touch_key_pkg::osc_run_s osc_run,
	input wire logic                    slot_overflow_pulse,
	input wire logic                    threshold_hit_pulse
);
	import touch_key_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       cfg_sel;
	logic       cfg_wr_q;
	logic [1:0] cfg_mod_q;
	logic [3:0] cfg_val_q;
	logic [3:0] ref_ok;
	assign cfg_sel = psel & penable & pwrite & (paddr[11:7] == 5'h01)
		& (paddr[4:0] == 5'h00);
	// a module may run its reference only with some key enabled
	assign ref_ok = {|key_input_enable[15:12], |key_input_enable[11:8],
		|key_input_enable[7:4], |key_input_enable[3:0]};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_wr_q <= 1'b0;
		end else begin
			cfg_wr_q <= cfg_sel;
		end
	end
	always_ff @(posedge pclk) begin
		cfg_mod_q <= paddr[6:5];
		cfg_val_q <= pwdata[3:0];
	end
	////////////////////////////////////////////////////////////////////////
	property p_key_en_value;
		cfg_wr_q |-> key_input_enable[cfg_mod_q*4 +: 4] == cfg_val_q;
	endproperty
	a_key_en_value: assert property (p_key_en_value)
		else $error("key enables differ from written value");
	property p_key_en_cause;
		!$stable(key_input_enable) |-> $past(cfg_sel);
	endproperty
	a_key_en_cause: assert property (p_key_en_cause)
		else $error("key enables changed without a write");
	property p_key_run_gate;
		(osc_run.key_run & ~key_input_enable) == 16'h0000;
	endproperty
	a_key_run_gate: assert property (p_key_run_gate)
		else $error("disabled key oscillator running");
	property p_ref_run_gate;
		(osc_run.ref_run & ~ref_ok) == 4'h0;
	endproperty
	a_ref_run_gate: assert property (p_ref_run_gate)
		else $error("reference runs in module without keys");
	property p_ovf_stops;
		slot_overflow_pulse |-> osc_run == 20'h00000;
	endproperty
	a_ovf_stops: assert property (p_ovf_stops)
		else $error("oscillators still run after overflow");
	property p_ovf_single;
		slot_overflow_pulse |=> !slot_overflow_pulse;
	endproperty
	a_ovf_single: assert property (p_ovf_single)
		else $error("overflow pulse longer than one cycle");
	property p_hit_single;
		threshold_hit_pulse |=> !threshold_hit_pulse;
	endproperty
	a_hit_single: assert property (p_hit_single)
		else $error("hit pulse longer than one cycle");
	property p_err_in_access;
		pslverr |-> psel && penable && pready;
	endproperty
	a_err_in_access: assert property (p_err_in_access)
		else $error("pslverr outside access phase");
	c_ovf: cover property (slot_overflow_pulse);
	c_hit: cover property (threshold_hit_pulse);
	c_cfg: cover property (cfg_wr_q);
endmodule : touch_key_checker

bind touch_key_scan_threshold touch_key_checker touch_key_checker_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .key_input_enable(key_input_enable),
	.osc_run(osc_run), .slot_overflow_pulse(slot_overflow_pulse),
	.threshold_hit_pulse(threshold_hit_pulse));

// File: sim/touch_key_scan_threshold_tb.sv
// self-checking bench: register map, manual scan, periodic threshold runs
// assumes the design, the package and the pad model are compiled first
module touch_key_scan_threshold_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import touch_key_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] key_osc_tick, key_input_enable;
	logic [3:0]  ref_osc_tick;
	logic        low_speed_rc_clock, periodic_trigger;
	logic        slot_overflow_pulse, threshold_hit_pulse;
	osc_run_s    osc_run;
	int          err_count = 0;
	int          compares = 0;
	int          hit_cnt = 0;
	localparam logic [11:0] CTRL = 12'h000;
	localparam logic [11:0] STAT = 12'h004;
	localparam logic [11:0] FUNC = 12'h008;

	touch_key_scan_threshold touch_key_scan_threshold_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.key_osc_tick(key_osc_tick), .ref_osc_tick(ref_osc_tick),
		.low_speed_rc_clock(low_speed_rc_clock),
		.periodic_trigger(periodic_trigger),
		.key_input_enable(key_input_enable), .osc_run(osc_run),
		.slot_overflow_pulse(slot_overflow_pulse),
		.threshold_hit_pulse(threshold_hit_pulse));
	touch_pad_model touch_pad_model_i (.pclk(pclk), .presetn(presetn),
		.osc_run(osc_run), .key_osc_tick(key_osc_tick),
		.ref_osc_tick(ref_osc_tick),
		.low_speed_rc_clock(low_speed_rc_clock));

	always #10 pclk = ~pclk;
	always @(posedge pclk) begin
		if (threshold_hit_pulse === 1'b1) begin
			hit_cnt <= hit_cnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] mod_addr(input int n,
		input logic [11:0] off);
		return 12'h080 + 12'(n * 32) + off;
	endfunction : mod_addr
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		if (n >= 50) err_count++;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd_chk(input string what, input logic [11:0] a,
		input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(what, exp, r);
	endtask : rd_chk
	task automatic wait_ovf;
		int n = 0;
		while (slot_overflow_pulse !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		chk("overflow pulse", 32'h1, {31'h0, slot_overflow_pulse});
		@(posedge pclk);
	endtask : wait_ovf
	task automatic retrigger;
		periodic_trigger <= 1'b1;
		@(posedge pclk);
		periodic_trigger <= 1'b0;
		wait_ovf();
	endtask : retrigger
	////////////////////////////////////////////////////////////////////////
	task automatic test_reset_values;
		logic [31:0] r;
		logic        e;
		for (int n = 0; n < 4; n++) begin
			rd_chk("map", mod_addr(n, 12'h004), 32'he4);
			rd_chk("th high", mod_addr(n, 12'h008), 32'h0);
			rd_chk("th low", mod_addr(n, 12'h00c), 32'h0);
			rd_chk("flags", mod_addr(n, 12'h010), 32'h0);
		end
		apb(1'b0, 12'h00c, 32'h0, r, e);
		chk("unmapped pslverr", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, r);
	endtask : test_reset_values
	task automatic test_key_enables;
		for (int n = 0; n < 4; n++) begin
			wr(mod_addr(n, 12'h000), 32'(n + 5));
			wr(mod_addr(n, 12'h004), 32'h1b);
			rd_chk("map", mod_addr(n, 12'h004), 32'h1b);
			// flags only clear by software, ones are ignored
			wr(mod_addr(n, 12'h010), 32'hfa);
			rd_chk("flags", mod_addr(n, 12'h010), 32'h0a);
			wr(mod_addr(n, 12'h010), 32'h0);
		end
		chk("enables", 32'h8765, {16'h0, key_input_enable});
		for (int n = 0; n < 4; n++) begin
			wr(mod_addr(n, 12'h000), 32'h0);
		end
	endtask : test_key_enables
	task automatic test_manual;
		logic [31:0] r;
		logic        e;
		wr(mod_addr(0, 12'h018), 32'hff);
		wr(mod_addr(0, 12'h000), 32'h3f);
		wr(mod_addr(0, 12'h004), 32'he5);
		wr(CTRL, 32'h01);
		wr(CTRL, 32'h05);
		// run state launches at this edge; look once it has settled
		@(negedge pclk);
		chk("osc_run", 32'h1_0002, {12'h0, osc_run});
		wait_ovf();
		chk("osc stopped", 32'h0, {12'h0, osc_run});
		rd_chk("status", STAT, 32'h1);
		apb(1'b0, mod_addr(0, 12'h014), 32'h0, r, e);
		chk("count window", 32'h1, {31'h0, r >= 60 && r <= 68});
		wr(CTRL, 32'h01);
		rd_chk("count cleared", mod_addr(0, 12'h014), 32'h0);
		rd_chk("func cleared", FUNC, 32'h0);
	endtask : test_manual
	task automatic test_periodic;
		int h;
		wr(mod_addr(0, 12'h000), 32'h02);
		wr(mod_addr(1, 12'h000), 32'h08);
		wr(mod_addr(1, 12'h018), 32'hff);
		wr(12'h100, 32'h0010);
		wr(12'h110, 32'hffff);
		wr(mod_addr(0, 12'h010), 32'h02);
		wr(mod_addr(1, 12'h010), 32'h08);
		h = hit_cnt;
		wr(CTRL, 32'h0a);
		wr(CTRL, 32'h0e);
		@(negedge pclk);
		chk("both modules", 32'h3_0082, {12'h0, osc_run});
		wait_ovf();
		chk("hit pulse", 32'(h + 1), 32'(hit_cnt));
		rd_chk("th low", mod_addr(0, 12'h00c), 32'h10);
		rd_chk("th high", mod_addr(0, 12'h008), 32'h0);
		rd_chk("flags", mod_addr(0, 12'h010), 32'h22);
		rd_chk("flags m1", mod_addr(1, 12'h010), 32'h08);
		wr(12'h100, 32'hffff);
		retrigger();
		chk("no hit", 32'(h + 1), 32'(hit_cnt));
		rd_chk("flag kept", mod_addr(0, 12'h010), 32'h22);
		wr(mod_addr(0, 12'h010), 32'h00);
		rd_chk("flag cleared", mod_addr(0, 12'h010), 32'h0);
		retrigger();
		rd_chk("lower hit", mod_addr(0, 12'h010), 32'h20);
		chk("hit pulse", 32'(h + 2), 32'(hit_cnt));
	endtask : test_periodic
	// four auto slots under module 0's counter; module 1 has no
	// reference running, so ignoring the shared select would hang
	task automatic test_auto;
		wr(CTRL, 32'h10);
		wr(STAT, 32'h0);
		wr(mod_addr(0, 12'h000), 32'h0f);
		wr(CTRL, 32'h14);
		wait_ovf();
		rd_chk("four slots", STAT, 32'h1);
		rd_chk("func count", FUNC, 32'h20);
	endtask : test_auto
	////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, periodic_trigger} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_reset_values();
		test_key_enables();
		test_manual();
		test_periodic();
		test_auto();
		report_and_stop();
	end
	// whole run needs under two thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		report_and_stop();
	end
endmodule : touch_key_scan_threshold_tb

// File: sim/touch_pad_model.sv
// behavioural pads: one sensing oscillator per key, one reference per
// module; ticks are one-cycle pulses synchronous to pclk
module touch_pad_model #(
	parameter int KEY_DIV = 2,
	parameter int REF_DIV = 4
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire touch_key_pkg::osc_run_s osc_run,
	output logic      [15:0]            key_osc_tick,
	output logic      [3:0]             ref_osc_tick,
	output logic                        low_speed_rc_clock
);
	import touch_key_pkg::*;
	int div_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 0;
			key_osc_tick <= 16'h0000;
			ref_osc_tick <= 4'h0;
			low_speed_rc_clock <= 1'b0;
		end else begin
			div_cnt <= div_cnt + 1;
			// a stopped oscillator gives no edges at all
			key_osc_tick <= (div_cnt % KEY_DIV == 0) ? osc_run.key_run
				: 16'h0000;
			ref_osc_tick <= (div_cnt % REF_DIV == 0) ? osc_run.ref_run
				: 4'h0;
			// rc runs free, even between scans
			if (div_cnt % 16 == 0) begin
				low_speed_rc_clock <= ~low_speed_rc_clock;
			end
		end
	end
endmodule : touch_pad_model
